// File: src/ssrg_top.sv
// Supply supervisor: reset stretch, watchdog, RAM strobe guard, early fail flag.
// Assumes comparator results arrive as asynchronous logic levels on pins.
// Behaviour
// (RULE1) RAM strobe passes when valid, else high
// (RULE2) Early fail flag follows the sense comparator
// (RULE3) Deep backup forces early fail flag low
// (RULE4) Backup mode fixes outputs, ignores timebase, kick
// (RULE5) Backup output follows supply against both levels
// (RULE6) Reset held while low, then stretched
// (RULE7) Supply-low flag low while supply low
// (RULE8) Processor toggles kick within long period
// (RULE9) Missed kick gives repeated reset pulses
// (RULE10) Constant kick level past timeout resets
// (RULE11) Miss flag low until next kick edge
// (RULE12) Floating kick input disables watchdog
// (RULE13) Timeouts selected by timebase pins
// (RULE14) First period after reset is long
// (RULE15) Count restarts after reset and kick edges
// (RULE16) Supply low sets miss flag, stops watchdog
// (RULE17) Active-high reset complements active-low reset
`timescale 1ns/10ps
`default_nettype none
module ssrg_top
  import ssrg_pkg::*;
#(
  parameter int unsigned P_UNIT_CYC = UNIT_CYC
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_supply_ok,
  input wire logic i_above_backup,
  input wire logic i_backup_margin_ok,
  input wire logic i_early_fail_sense,
  input wire logic i_ram_strobe_n,
  input wire logic i_kick_input,
  input wire logic i_kick_float,
  input wire logic i_timebase_choose,
  input wire logic i_timebase_pin,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_reset_n,
  output logic o_reset,
  output logic o_ram_strobe_n,
  output logic o_early_fail_flag_n,
  output logic o_kick_miss_flag_n,
  output logic o_backup_active,
  output logic o_supply_low_n,
  output logic o_irq
);

  ssrg_pins_t raw; // Raw pin bundle
  ssrg_pins_t s; // Synchronised pin bundle
  logic ms_tick; // 1 ms enable
  logic kick_prev_q; // Kick level one cycle ago
  logic tbp_prev_q; // Timebase pin level one cycle ago
  logic ok_prev_q; // Supply valid one cycle ago
  ssrg_state_t state_q; // Supervisor state
  ssrg_state_t state_d;
  logic [12:0] cnt_q; // Interval counter
  logic [12:0] cnt_d;
  logic first_q; // Long first period pending
  logic ext_mode; // External clock timebase
  logic unit_en; // One timebase unit elapsed
  logic kick_live; // Watchdog enabled by a driven kick input
  logic kick_edge; // Kick transition of either polarity
  logic [12:0] reset_last; // Last count of reset width
  logic [12:0] wd_last; // Last count of watchdog period
  logic timeout; // Watchdog expired this cycle
  logic backup_mode; // Supply below both levels
  logic ef_d; // Next early fail flag
  logic [7:0] status_q; // Sticky event bits
  logic [7:0] status_d;
  logic [7:0] mask_q; // Interrupt mask
  logic [7:0] events; // Event pulses this cycle
  logic [7:0] rdata_q; // Read data
  logic reset_n_q;
  logic reset_q;
  logic strobe_q;
  logic ef_q;
  logic miss_q;
  logic batt_q;
  logic low_q;
  logic irq_q;

  // Gather pins into one bundle
  always_comb
  begin
    raw.supply_ok = i_supply_ok;
    raw.above_backup = i_above_backup;
    raw.backup_margin_ok = i_backup_margin_ok;
    raw.early_fail_above = i_early_fail_sense;
    raw.ram_strobe_n = i_ram_strobe_n;
    raw.kick_input = i_kick_input;
    raw.kick_float = i_kick_float;
    raw.timebase_choose = i_timebase_choose;
    raw.timebase_pin = i_timebase_pin;
  end

  // Pin synchroniser
  ssrg_sync #(
    .W(PIN_W),
    .RST(PIN_RST)
  ) u_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_d(raw),
    .o_q(s)
  );

  // Internal oscillator unit
  ssrg_tick #(
    .P_DIV(P_UNIT_CYC)
  ) u_tick (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .o_tick(ms_tick)
  );

  // Previous levels for edge detection
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      kick_prev_q <= PIN_RST.kick_input;
      tbp_prev_q <= PIN_RST.timebase_pin;
      ok_prev_q <= 1'b0;
    end
    else
    begin
      kick_prev_q <= s.kick_input;
      tbp_prev_q <= s.timebase_pin;
      ok_prev_q <= s.supply_ok;
    end
  end

  // Timebase selection
  always_comb
  begin
    ext_mode = ~s.timebase_choose; // see (RULE13)
    unit_en = ext_mode ? (s.timebase_pin & ~tbp_prev_q) : ms_tick;
    kick_live = ~s.kick_float; // see (RULE12)
    kick_edge = s.kick_input ^ kick_prev_q;
    reset_last = ext_mode ? EXT_RESET_LAST : INT_RESET_LAST; // see (RULE13)
    // First period long; in internal mode pin high (floating) keeps long period
    if (ext_mode)
      wd_last = first_q ? EXT_FIRST_LAST : EXT_NORM_LAST; // see (RULE13) see (RULE14)
    else
      wd_last = (first_q | s.timebase_pin) ? INT_LONG_LAST : INT_SHORT_LAST; // see (RULE14)
    backup_mode = ~s.supply_ok & ~s.above_backup;
  end

  // Watchdog expiry: constant kick level for a full period
  // A period shortened by a pin change mid-count expires at the next timebase unit instead of wrapping
  assign timeout = (state_q == ST_RUN) && kick_live && !kick_edge && unit_en
                   && (cnt_q >= wd_last); // see (RULE10)

  // Next state and interval count
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_LOW:
      begin
        cnt_d = 13'h0;
        if (s.supply_ok)
          state_d = ST_HOLD; // see (RULE6)
      end
      ST_HOLD, ST_PULSE:
      begin
        // Reset width, then restart the watchdog
        if (unit_en)
        begin
          // Reaching or passing the end counts, so a mode change mid-count cannot wrap
          if (cnt_q >= reset_last)
          begin
            state_d = ST_RUN;
            cnt_d = 13'h0; // see (RULE15)
          end
          else
            cnt_d = cnt_q + 13'h1;
        end
      end
      ST_RUN:
      begin
        if (!kick_live)
          cnt_d = 13'h0; // see (RULE12)
        else if (kick_edge)
          cnt_d = 13'h0; // see (RULE15)
        else if (timeout)
        begin
          state_d = ST_PULSE; // see (RULE9)
          cnt_d = 13'h0;
        end
        else if (unit_en)
          cnt_d = cnt_q + 13'h1;
      end
      default:
      begin
        state_d = ST_LOW;
        cnt_d = 13'h0;
      end
    endcase
    // Supply loss overrides all; timebase and kick then ignored
    if (!s.supply_ok)
    begin
      state_d = ST_LOW; // see (RULE4) see (RULE16)
      cnt_d = 13'h0;
    end
  end

  // State and counter registers
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      state_q <= ST_LOW;
      cnt_q <= 13'h0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Long first period after each reset, short after first kick edge
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      first_q <= 1'b1;
    else if (state_q != ST_RUN)
      first_q <= 1'b1; // see (RULE14)
    else if (kick_live && kick_edge)
      first_q <= 1'b0; // see (RULE14)
  end

  // Reset outputs follow the next state
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      reset_n_q <= 1'b0;
      reset_q <= 1'b1;
    end
    else
    begin
      reset_n_q <= (state_d == ST_RUN); // see (RULE6) see (RULE9)
      reset_q <= (state_d != ST_RUN); // see (RULE17)
    end
  end

  // Kick miss flag
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      miss_q <= 1'b1;
    else if (!s.supply_ok)
      miss_q <= 1'b1; // see (RULE16) see (RULE4)
    else if (timeout)
      miss_q <= 1'b0; // see (RULE11)
    else if (kick_live && kick_edge)
      miss_q <= 1'b1; // see (RULE11)
  end

  // Early fail flag, forced low in deep backup
  assign ef_d = (backup_mode && !s.backup_margin_ok) ? 1'b0 : s.early_fail_above; // see (RULE2) see (RULE3)

  // Supply-dependent outputs
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      strobe_q <= 1'b1;
      ef_q <= 1'b0;
      batt_q <= 1'b0;
      low_q <= 1'b0;
    end
    else
    begin
      strobe_q <= s.supply_ok ? s.ram_strobe_n : 1'b1; // see (RULE1)
      ef_q <= ef_d;
      low_q <= s.supply_ok; // see (RULE7)
      // Between the two levels the output keeps its value
      if (s.supply_ok && s.above_backup)
        batt_q <= 1'b0; // see (RULE5)
      else if (backup_mode)
        batt_q <= 1'b1; // see (RULE5) see (RULE4)
    end
  end

  // Event pulses for the sticky status
  always_comb
  begin
    events = 8'h00;
    events[EV_TIMEOUT] = timeout;
    events[EV_SUPPLY_LOW] = ok_prev_q & ~s.supply_ok;
    events[EV_EARLY_FAIL] = ef_q & ~ef_d;
  end

  // Write one clears; a new event wins over the clear
  always_comb
  begin
    status_d = status_q;
    if (i_wr && (i_addr == ADDR_STATUS))
      status_d = status_q & ~i_wdata;
    status_d = status_d | events;
  end

  // Status, mask and interrupt
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      status_q <= STATUS_RST;
      mask_q <= MASK_RST;
      irq_q <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      if (i_wr && (i_addr == ADDR_MASK))
        mask_q <= i_wdata;
      irq_q <= |(status_d & mask_q);
    end
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      rdata_q <= 8'h00;
    else if (i_rd)
    begin
      case (i_addr)
        ADDR_STATUS: rdata_q <= status_q;
        ADDR_MASK: rdata_q <= mask_q;
        ADDR_STATE: rdata_q <= {2'h0, state_q, first_q, miss_q, ext_mode, kick_live};
        default: rdata_q <= 8'h00;
      endcase
    end
    else
      rdata_q <= 8'h00;
  end

  assign o_rdata = rdata_q;
  assign o_reset_n = reset_n_q;
  assign o_reset = reset_q;
  assign o_ram_strobe_n = strobe_q;
  assign o_early_fail_flag_n = ef_q;
  assign o_kick_miss_flag_n = miss_q;
  assign o_backup_active = batt_q;
  assign o_supply_low_n = low_q;
  assign o_irq = irq_q;

  // Checks on the supervisor outputs
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  a_strobe_pass: assert property (s.supply_ok |=> o_ram_strobe_n == $past(s.ram_strobe_n)) // see (RULE1)
    else $error("RAM strobe not passed through");
  a_strobe_block: assert property (!s.supply_ok |=> o_ram_strobe_n) // see (RULE1)
    else $error("RAM strobe not blocked");
  a_early_forced: assert property ((backup_mode && !s.backup_margin_ok) |=> !o_early_fail_flag_n) // see (RULE3)
    else $error("Early fail flag not forced low");
  a_early_follow: assert property (s.supply_ok |=> o_early_fail_flag_n == $past(s.early_fail_above)) // see (RULE2)
    else $error("Early fail flag does not follow sense");
  a_backup_levels: assert property ((s.supply_ok && s.above_backup) ##1 backup_mode |=> o_backup_active) // see (RULE5)
    else $error("Backup output wrong");
  a_reset_held: assert property (!s.supply_ok |=> !o_reset_n && o_reset && !o_supply_low_n) // see (RULE6)
    else $error("Reset or low flag released while supply low");
  a_reset_pair: assert property (o_reset == !o_reset_n) // see (RULE17)
    else $error("Reset outputs not complementary");
  a_timeout_pulse: assert property (timeout && s.supply_ok |=> !o_reset_n && !o_kick_miss_flag_n) // see (RULE9)
    else $error("Timeout did not reset and flag");
  a_miss_supply: assert property (!s.supply_ok |=> o_kick_miss_flag_n) // see (RULE16)
    else $error("Miss flag low while supply low");
  a_float_quiet: assert property ((state_q == ST_RUN) && !kick_live && s.supply_ok |=> o_reset_n && $stable(o_kick_miss_flag_n)) // see (RULE12)
    else $error("Watchdog acted while kick floating");

  c_timeout: cover property (timeout);
  c_release: cover property (state_q == ST_HOLD ##1 state_q == ST_RUN);
  c_backup: cover property ($rose(o_backup_active));

endmodule : ssrg_top
`default_nettype wire

// File: common/ssrg_pkg.sv
// Shared constants and types of the supply supervisor with RAM guard.
// Assumes a single 100 MHz clock and a synchronous, active-high reset.
package ssrg_pkg;

  // Clock rate and the 1 ms time unit of the internal oscillator
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned UNIT_MS = 1;
  localparam int unsigned UNIT_CYC = CLK_HZ / 1000 * UNIT_MS;

  // Internal oscillator timing, in 1 ms units
  localparam int unsigned INT_RESET_MS = 200;
  localparam int unsigned INT_SHORT_MS = 100;
  localparam int unsigned INT_LONG_MS = 1600;

  // External clock timing, in timebase clocks
  localparam int unsigned EXT_NORM_CLKS = 1024;
  localparam int unsigned EXT_FIRST_CLKS = 4096;
  localparam int unsigned EXT_RESET_CLKS = 2048;

  // Last counter value of each interval (counter starts at zero)
  localparam logic [12:0] INT_RESET_LAST = 13'(INT_RESET_MS - 1);
  localparam logic [12:0] INT_SHORT_LAST = 13'(INT_SHORT_MS - 1);
  localparam logic [12:0] INT_LONG_LAST = 13'(INT_LONG_MS - 1);
  localparam logic [12:0] EXT_NORM_LAST = 13'(EXT_NORM_CLKS - 1);
  localparam logic [12:0] EXT_FIRST_LAST = 13'(EXT_FIRST_CLKS - 1);
  localparam logic [12:0] EXT_RESET_LAST = 13'(EXT_RESET_CLKS - 1);

  // Register port map
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_MASK = 2'h1;
  localparam logic [1:0] ADDR_STATE = 2'h2;

  // Status and mask bit positions
  localparam int unsigned EV_TIMEOUT = 0;
  localparam int unsigned EV_SUPPLY_LOW = 1;
  localparam int unsigned EV_EARLY_FAIL = 2;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;

  // Supervisor states
  typedef enum logic [1:0] {
    ST_LOW   = 2'b00,
    ST_HOLD  = 2'b01,
    ST_RUN   = 2'b10,
    ST_PULSE = 2'b11
  } ssrg_state_t;

  // Pin inputs travelling together through the synchroniser
  typedef struct packed {
    logic supply_ok;
    logic above_backup;
    logic backup_margin_ok;
    logic early_fail_above;
    logic ram_strobe_n;
    logic kick_input;
    logic kick_float;
    logic timebase_choose;
    logic timebase_pin;
  } ssrg_pins_t;

  localparam int unsigned PIN_W = $bits(ssrg_pins_t);
  localparam ssrg_pins_t PIN_RST = '{supply_ok: 1'b0, above_backup: 1'b0, backup_margin_ok: 1'b0,
                                     early_fail_above: 1'b0, ram_strobe_n: 1'b1, kick_input: 1'b0,
                                     kick_float: 1'b1, timebase_choose: 1'b1, timebase_pin: 1'b1};

endpackage : ssrg_pkg

// File: src/ssrg_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous pins; reset value is a parameter.
`timescale 1ns/10ps
`default_nettype none
module ssrg_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] s1_q; // First stage, read only by the second
  logic [W-1:0] s2_q; // Second stage
  logic [W-1:0] s3_q; // Third stage
  logic [W-1:0] q_q; // Filtered level

  // Shift chain
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
    end
    else
    begin
      s1_q <= i_d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept a bit once second and third stage agree
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      q_q <= RST;
    else
      q_q <= (s2_q & s3_q) | (q_q & (s2_q ^ s3_q));
  end

  assign o_q = q_q;

endmodule : ssrg_sync
`default_nettype wire

// File: src/ssrg_tick.sv
// Divider giving a one-cycle enable every P_DIV clocks.
// Assumes one clock domain; restarts from zero at reset.
`timescale 1ns/10ps
`default_nettype none
module ssrg_tick #(
  parameter int unsigned P_DIV = 100000
) (
  input wire logic i_clk,
  input wire logic i_srst,
  output logic o_tick
);

  logic [31:0] cnt_q; // Cycle counter
  logic tick_q; // Enable pulse

  // Count cycles and pulse on wrap
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end
    else if (cnt_q == 32'(P_DIV - 1))
    begin
      cnt_q <= 32'h0;
      tick_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 32'h1;
      tick_q <= 1'b0;
    end
  end

  assign o_tick = tick_q;

endmodule : ssrg_tick

// File: tb/ssrg_cpu_model.sv
// CPU side model: toggles the watchdog kick line at a fixed gap while enabled.
// Assumes the bench clock; the bench drives the RAM strobe itself.
`timescale 1ns/10ps
`default_nettype none
module ssrg_cpu_model #(
  parameter int unsigned P_GAP = 800
) (
  input wire logic i_clk,
  input wire logic i_en,
  output logic o_kick
);
  int unsigned gap_q = 0; // Cycles since the last kick edge
  logic kick_q = 1'h0; // Kick line level
  assign o_kick = kick_q;
  // Kicks well inside the watchdog period while enabled; stops dead when not
  always @(posedge i_clk)
  begin
    if (!i_en)
      gap_q <= 0;
    else if (gap_q == P_GAP - 1)
    begin
      gap_q <= 0;
      kick_q <= ~kick_q;
    end
    else
      gap_q <= gap_q + 1;
  end
endmodule : ssrg_cpu_model
`default_nettype wire

// File: tb/test_supply_supervisor_ram_guard.sv
// Bench for the supply supervisor: power, watchdog, backup and register runs.
// Assumes ssrg_pkg, the CPU kick model and one 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module test_supply_supervisor_ram_guard;
  import ssrg_pkg::*;
  localparam int unsigned UC = 10; // Clocks per time unit, shortened
  logic i_clk = 1'h0;
  logic i_srst = 1'h1;
  // Pin levels driven by the bench
  logic sup = 1'h0, abv = 1'h0, mrg = 1'h0, sense = 1'h0, str_n = 1'h0, kick = 1'h0;
  logic flt = 1'h0, tbc = 1'h1, ext_on = 1'h0, ext_clk = 1'h0, wr = 1'h0, rd = 1'h0, en = 1'h0;
  logic [1:0] addr = 2'h0;
  logic [1:0] div = 2'h0;
  logic tbp = 1'h0; // Timebase pin level in internal oscillator mode
  logic [7:0] wdata = 8'h00;
  // Design outputs and model kick
  logic m_kick, rst_n, rst, ram_n, ef_n, miss_n, batt, low_n, irq;
  logic [7:0] rdata;
  logic [7:0] rv;
  int fails = 0;
  int tests_run = 0;
  int n;

  ssrg_top #(.P_UNIT_CYC(UC)) uut (
    .i_clk(i_clk), .i_srst(i_srst), .i_supply_ok(sup), .i_above_backup(abv),
    .i_backup_margin_ok(mrg), .i_early_fail_sense(sense), .i_ram_strobe_n(str_n),
    .i_kick_input(m_kick ^ kick), .i_kick_float(flt), .i_timebase_choose(tbc),
    .i_timebase_pin(ext_on ? ext_clk : tbp), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_reset_n(rst_n), .o_reset(rst),
    .o_ram_strobe_n(ram_n), .o_early_fail_flag_n(ef_n), .o_kick_miss_flag_n(miss_n),
    .o_backup_active(batt), .o_supply_low_n(low_n), .o_irq(irq));

  ssrg_cpu_model #(.P_GAP(800)) cpu (.i_clk(i_clk), .i_en(en), .o_kick(m_kick));

  always #5 i_clk = ~i_clk;

  // External timebase clock: one rising edge every 8 system clocks
  always @(posedge i_clk)
  begin
    if (ext_on)
    begin
      div <= div + 2'h1;
      if (div == 2'h3)
        ext_clk <= ~ext_clk;
    end
  end

  task automatic end_of_test;
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task automatic chkb(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chkb

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  // Cycle counts are judged against a window for synchroniser and tick phase
  task automatic chkn(input string nm, input int lo, input int hi, input int g);
    tests_run++;
    if (g < lo || g > hi)
    begin
      fails++;
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chkn

  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
  endtask : tick

  // Counts cycles until reset_n reaches a level; gives up after mx cycles
  task automatic wait_rn(input logic v, input int mx);
    n = 0;
    while (rst_n !== v)
    begin
      if (n == mx)
      begin
        fails++;
        $display("BAD wait reset_n expected %h seen %h", v, rst_n);
        break;
      end
      @(posedge i_clk);
      #1;
      n++;
    end
  endtask : wait_rn

  // Waits for the model's next kick edge; a missing kick counts as a mismatch
  task automatic wait_kick;
    rv[0] = m_kick;
    for (n = 0; m_kick === rv[0] && n < 900; n++)
      @(posedge i_clk);
    chkn("kick_gap", 1, 899, n);
  endtask : wait_kick

  // Counts the cycles with reset_n not high over k cycles
  task automatic count_resets(input int k);
    n = 0;
    repeat (k)
    begin
      @(posedge i_clk);
      #1;
      n += int'(rst_n !== 1'h1);
    end
  endtask : count_resets

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge i_clk);
    wr <= 1'h0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge i_clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge i_clk);
    rd <= 1'h0;
    #1;
    d = rdata;
  endtask : reg_rd

  initial
  begin
    tick(3);
    i_srst <= 1'h0;
    tick(8);
    #1;
    chkb("reset_n", 1'h0, rst_n);
    chkb("reset", 1'h1, rst);
    chkb("ram_n", 1'h1, ram_n);
    chkb("low_n", 1'h0, low_n);
    // Supply comes up: reset stays on for the stretch time
    @(posedge i_clk);
    {sup, abv, mrg} <= 3'h7;
    wait_rn(1'h1, 2100);
    chkn("stretch", 1990, 2030, n);
    chkb("reset", 1'h0, rst);
    chkb("batt", 1'h0, batt);
    chkb("low_n", 1'h1, low_n);
    // RAM strobe and early fail flag follow their inputs
    for (int v = 0; v < 2; v++)
    begin
      @(posedge i_clk);
      str_n <= 1'(v);
      sense <= 1'(v);
      tick(8);
      #1;
      chkb("ram_n", 1'(v), ram_n);
      chkb("ef_n", 1'(v), ef_n);
    end
    // Regular kicks from the model keep reset off for 2500 cycles
    @(posedge i_clk);
    en <= 1'h1;
    tick(2500);
    #1;
    chkb("reset_n", 1'h1, rst_n);
    // Timebase pin high selects the long period: silence past the short one gives no reset
    @(posedge i_clk);
    tbp <= 1'h1;
    wait_kick();
    en <= 1'h0;
    count_resets(1500);
    chkn("long_quiet", 0, 0, n);
    @(posedge i_clk);
    en <= 1'h1;
    wait_kick();
    tbp <= 1'h0;
    wait_kick();
    en <= 1'h0;
    wait_rn(1'h0, 1100);
    chkn("short", 990, 1030, n);
    wait_rn(1'h1, 2100);
    chkn("pulse", 1990, 2030, n);
    chkb("miss_n", 1'h0, miss_n);
    wait_rn(1'h0, 16100);
    chkn("first", 15990, 16040, n);
    wait_rn(1'h1, 2100);
    chkb("miss_n", 1'h0, miss_n);
    // Timeout event, mask, interrupt and clear
    reg_rd(ADDR_STATUS, rv);
    chkb("timeout_ev", 1'h1, rv[0]);
    chkb("irq", 1'h0, irq);
    reg_wr(ADDR_MASK, 8'h01);
    tick(2);
    #1;
    chkb("irq", 1'h1, irq);
    reg_wr(ADDR_STATE, 8'hff);
    reg_rd(ADDR_MASK, rv);
    chk8("mask", 8'h01, rv);
    reg_wr(ADDR_STATUS, 8'h01);
    tick(2);
    #1;
    chkb("irq", 1'h0, irq);
    reg_rd(2'h3, rv);
    chk8("unmapped", 8'h00, rv);
    // Supply drops below both levels: backup mode
    @(posedge i_clk);
    {sup, abv, str_n} <= 3'h0;
    tick(8);
    #1;
    chkb("batt", 1'h1, batt);
    chkb("reset_n", 1'h0, rst_n);
    chkb("ram_n", 1'h1, ram_n);
    chkb("miss_n", 1'h1, miss_n);
    chkb("low_n", 1'h0, low_n);
    chkb("ef_n", 1'h1, ef_n);
    @(posedge i_clk);
    mrg <= 1'h0;
    tick(8);
    #1;
    chkb("ef_n", 1'h0, ef_n);
    reg_rd(ADDR_STATUS, rv);
    chkb("low_ev", 1'h1, rv[1]);
    // External timebase: stretch of 2048 and period of 1024 timebase clocks
    @(posedge i_clk);
    {tbc, ext_on, sup, abv, mrg} <= 5'h0f;
    wait_rn(1'h1, 16600);
    chkn("ext_stretch", 16300, 16500, n);
    chkb("batt", 1'h0, batt);
    @(posedge i_clk);
    kick <= ~kick;
    wait_rn(1'h0, 8500);
    chkn("ext_period", 8150, 8300, n);
    wait_rn(1'h1, 16600);
    chkb("miss_n", 1'h0, miss_n);
    @(posedge i_clk);
    kick <= ~kick;
    tick(8);
    #1;
    chkb("miss_n", 1'h1, miss_n);
    // Floating kick line: no reset however long it sits
    @(posedge i_clk);
    flt <= 1'h1;
    count_resets(9000);
    chkn("float_resets", 0, 0, n);
    end_of_test();
  end
endmodule : test_supply_supervisor_ram_guard
`default_nettype wire
